// [src/lcd_pkg.sv]
// Constants and types shared by the memory-panel serial update logic
package lcd_pkg;
   // -----------------------------------------------------------------
   // Frame layout on the serial link
   // -----------------------------------------------------------------
   localparam int PIX_W      = 184;
   localparam int ADDR_W     = 6;
   localparam int LINES      = 64;
   localparam int MODE_BITS  = 8;
   localparam int LINE_DUMMY = 2;
   localparam int CNT_W      = 8;
   // Flag positions inside the captured mode field
   localparam int FLAG_UPDATE = 0;
   localparam int FLAG_SPARE  = 1;
   localparam int FLAG_CLEAR  = 2;
   // Reset and erase values
   localparam logic [PIX_W-1:0]  PIX_WHITE = {PIX_W{1'b1}};
   localparam logic [ADDR_W-1:0] ADDR_LAST = 6'h3f;
   localparam logic              POL_INIT  = 1'b0;

   // -----------------------------------------------------------------
   // Link-side receive states
   // -----------------------------------------------------------------
   typedef enum logic [3:0] {
      LS_MODE = 4'h1,
      LS_ADDR = 4'h2,
      LS_PIX  = 4'h4,
      LS_TAIL = 4'h8
   } link_state_t;
endpackage : lcd_pkg

// [src/pixel_mem_if.sv]
// Carrier between the update controller and the pixel memory
`timescale 1ns/1ps
interface pixel_mem_if;
   import lcd_pkg::*;
   logic              we;
   logic [ADDR_W-1:0] waddr;
   logic [PIX_W-1:0]  wdata;
   logic [ADDR_W-1:0] raddr;
   logic [PIX_W-1:0]  rdata;
   modport ctrl  (output we, output waddr, output wdata, output raddr, input rdata);
   modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : pixel_mem_if

// [src/pixel_mem.sv]
// Pixel memory: one row per gate line, registered read port
`timescale 1ns/1ps
module pixel_mem
   import lcd_pkg::*;
(
   input wire logic     CLK,
   pixel_mem_if.store   port
);
   logic [PIX_W-1:0] rows [LINES];

   // -----------------------------------------------------------------
   // Write and registered read
   // -----------------------------------------------------------------
   // No reset: contents are undefined until the host clears the panel
   always_ff @(posedge CLK)
   begin
      if (port.we)
      begin
         rows[port.waddr] <= port.wdata;
      end
      port.rdata <= rows[port.raddr];
   end
endmodule : pixel_mem

// [src/memory_lcd_serial_update.sv]
// Serial pixel update receiver and common polarity control of the panel
// Summary of operation
// - Update flag high rewrites unless clear flag also high; low keeps memory unless clear flag high
// - Update mode stores many lines per frame
// - Display mode leaves pixel memory untouched
// - All clear erases memory to white
// - Each line carries 184 pixels, high=white
// - Six address bits, binary, LSB first
// - Incoming pixels wait in first latch
// - Line is committed after its own dummy bits
// - No polarity inversion while enable low
// - Inversion rise outside frame toggles polarity
`timescale 1ns/1ps
module memory_lcd_serial_update
   import lcd_pkg::*;
(
   input  wire logic              CLK,
   input  wire logic              RESET,
   input  wire logic              SCLK,
   input  wire logic              SCS,
   input  wire logic              SI,
   input  wire logic              PANEL_SHOW_ENABLE,
   input  wire logic              COMMON_INVERT_IN,
   input  wire logic [ADDR_W-1:0] SCAN_LINE,
   output      logic [PIX_W-1:0]  SCAN_PIXELS,
   output      logic              COMMON_POLARITY,
   output      logic              CLEAR_BUSY,
   output      logic [ADDR_W-1:0] LAST_LINE
);
   // -----------------------------------------------------------------
   // State records
   // -----------------------------------------------------------------
   typedef struct packed {
      link_state_t       state;
      logic [CNT_W-1:0]  cnt;
      logic [2:0]        mode;
      logic [ADDR_W-1:0] addr;
      logic [PIX_W-1:0]  pix;
   } link_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [PIX_W-1:0]  pix;
      logic              wr_tog;
      logic              clr_tog;
   } hold_t;

   typedef struct packed {
      logic [2:0]        wr_s;
      logic [2:0]        clr_s;
      logic [2:0]        scs_s;
      logic [2:0]        ext_s;
      logic [1:0]        panel_show_enable_s;
      logic              pol;
      logic              pend;
      logic              clr_busy;
      logic [ADDR_W-1:0] clr_idx;
      logic [ADDR_W-1:0] last_line;
   } core_t;

   localparam link_t LINK_RESET = '{state: LS_MODE, default: '0};

   link_t link_r, link_nxt;
   hold_t hold_r, hold_nxt;
   core_t core_r, core_nxt;
   logic  line_done;
   logic  clear_req;
   logic  wr_evt;
   logic  clr_evt;
   logic  ext_rise;
   logic  scs_fall;

   pixel_mem_if mem ();

   // True on the last bit of a field of n bits
   function automatic logic last_bit(input logic [CNT_W-1:0] cnt, input int n);
      last_bit = (cnt == CNT_W'(n - 1));
   endfunction : last_bit

   // -----------------------------------------------------------------
   // Link domain: bit receiver on SCLK
   // -----------------------------------------------------------------
   // Frame-scoped state; chip select low holds it at the frame start
   always_comb
   begin
      link_nxt = link_r;
      link_nxt.cnt = link_r.cnt + 8'h01;
      case (link_r.state)
         LS_MODE:
         begin
            if (link_r.cnt < CNT_W'(3))
               link_nxt.mode = {SI, link_r.mode[2:1]};
            if (last_bit(link_r.cnt, MODE_BITS))
            begin
               link_nxt.state = LS_ADDR;
               link_nxt.cnt   = '0;
            end
         end
         LS_ADDR:
         begin
            link_nxt.addr = {SI, link_r.addr[ADDR_W-1:1]};
            if (last_bit(link_r.cnt, ADDR_W))
            begin
               link_nxt.state = LS_PIX;
               link_nxt.cnt   = '0;
            end
         end
         LS_PIX:
         begin
            link_nxt.pix = {SI, link_r.pix[PIX_W-1:1]};
            if (last_bit(link_r.cnt, PIX_W))
            begin
               link_nxt.state = LS_TAIL;
               link_nxt.cnt   = '0;
            end
         end
         LS_TAIL:
         begin
            // Dummy bit levels are never looked at
            if (last_bit(link_r.cnt, LINE_DUMMY))
            begin
               link_nxt.state = LS_ADDR;
               link_nxt.cnt   = '0;
            end
         end
         default:
         begin
            link_nxt = LINK_RESET;
         end
      endcase
   end

   // Sampled only while chip select is high
   always_ff @(posedge SCLK or negedge SCS)
   begin
      if (!SCS)
         link_r <= LINK_RESET;
      else
         link_r <= link_nxt;
   end

   // Hand-off latch and event toggles outlive the frame
   assign line_done = (link_r.state == LS_TAIL) && last_bit(link_r.cnt, LINE_DUMMY)
                      && link_r.mode[FLAG_UPDATE] && !link_r.mode[FLAG_CLEAR];
   assign clear_req = (link_r.state == LS_MODE) && last_bit(link_r.cnt, MODE_BITS)
                      && !link_r.mode[FLAG_UPDATE] && link_r.mode[FLAG_CLEAR];

   always_comb
   begin
      hold_nxt = hold_r;
      if (line_done)
      begin
         hold_nxt.addr   = link_r.addr;
         hold_nxt.pix    = link_r.pix;
         hold_nxt.wr_tog = ~hold_r.wr_tog;
      end
      if (clear_req)
         hold_nxt.clr_tog = ~hold_r.clr_tog;
   end

   // A line takes nearly 200 SCLK periods, so the held word is stable long
   // before the next hand-off; the core reads it only after the toggle syncs
   always_ff @(posedge SCLK or posedge RESET)
   begin
      if (RESET)
         hold_r <= '0;
      else
         hold_r <= hold_nxt;
   end

   // -----------------------------------------------------------------
   // Core domain: synchronisers, memory writes, common polarity
   // -----------------------------------------------------------------
   assign wr_evt   = core_r.wr_s[1] ^ core_r.wr_s[2];
   assign clr_evt  = core_r.clr_s[1] ^ core_r.clr_s[2];
   assign ext_rise = core_r.ext_s[1] & ~core_r.ext_s[2];
   assign scs_fall = ~core_r.scs_s[1] & core_r.scs_s[2];

   always_comb
   begin
      core_nxt = core_r;
      core_nxt.wr_s   = {core_r.wr_s[1:0], hold_r.wr_tog};
      core_nxt.clr_s  = {core_r.clr_s[1:0], hold_r.clr_tog};
      core_nxt.scs_s  = {core_r.scs_s[1:0], SCS};
      core_nxt.ext_s  = {core_r.ext_s[1:0], COMMON_INVERT_IN};
      core_nxt.panel_show_enable_s = {core_r.panel_show_enable_s[0], PANEL_SHOW_ENABLE};
      // Polarity freezes and pending flips drop while enable is low
      if (!core_r.panel_show_enable_s[1])
         core_nxt.pend = 1'b0;
      else if (scs_fall && core_r.pend)
      begin
         core_nxt.pol  = ~core_r.pol;
         core_nxt.pend = 1'b0;
      end
      else if (ext_rise && core_r.scs_s[1])
         core_nxt.pend = 1'b1;
      else if (ext_rise)
         core_nxt.pol = ~core_r.pol;
      // Erase sweep, one row per cycle
      if (clr_evt)
      begin
         core_nxt.clr_busy = 1'b1;
         core_nxt.clr_idx  = '0;
      end
      else if (core_r.clr_busy)
      begin
         core_nxt.clr_idx  = core_r.clr_idx + 6'h01;
         core_nxt.clr_busy = (core_r.clr_idx != ADDR_LAST);
      end
      if (wr_evt && !core_r.clr_busy)
         core_nxt.last_line = hold_r.addr;
   end

   always_ff @(posedge CLK)
   begin
      if (RESET)
         core_r <= '{pol: POL_INIT, default: '0};
      else
         core_r <= core_nxt;
   end

   // Memory port; erase wins, a line landing inside a sweep is dropped
   assign mem.we    = core_r.clr_busy || wr_evt;
   assign mem.waddr = core_r.clr_busy ? core_r.clr_idx : hold_r.addr;
   assign mem.wdata = core_r.clr_busy ? PIX_WHITE : hold_r.pix;
   assign mem.raddr = SCAN_LINE;

   pixel_mem u_mem (
      .CLK  (CLK),
      .port (mem.store)
   );

   // Outputs
   assign SCAN_PIXELS     = mem.rdata;
   assign COMMON_POLARITY = core_r.pol;
   assign CLEAR_BUSY      = core_r.clr_busy;
   assign LAST_LINE       = core_r.last_line;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   chk_mode_gate: assert property (@(posedge SCLK) disable iff (!SCS)
      (link_r.state == LS_TAIL && !link_r.mode[FLAG_UPDATE]) |=> $stable(hold_r.wr_tog))
      else $error("line handed off outside update mode");
   chk_line_commit: assert property (@(posedge SCLK) disable iff (!SCS)
      line_done |=> (hold_r.wr_tog != $past(hold_r.wr_tog)) && link_r.state == LS_ADDR)
      else $error("finished line not handed off");
   chk_pix_length: assert property (@(posedge SCLK) disable iff (!SCS)
      $rose(link_r.state == LS_PIX) |-> (link_r.state == LS_PIX) [*8])
      else $error("pixel field shorter than expected");
   chk_clear_req: assert property (@(posedge SCLK) disable iff (!SCS)
      clear_req |=> hold_r.clr_tog != $past(hold_r.clr_tog))
      else $error("all clear not forwarded");
   chk_frame_idle: assert property (@(posedge CLK) disable iff (RESET)
      (!core_r.scs_s[2] && !core_r.scs_s[1]) |-> link_r.state == LS_MODE)
      else $error("receiver active outside frame");
   chk_enable_freeze: assert property (@(posedge CLK) disable iff (RESET)
      !core_r.panel_show_enable_s[1] |=> $stable(core_r.pol))
      else $error("polarity changed while enable low");
   chk_invert_edge: assert property (@(posedge CLK) disable iff (RESET)
      (ext_rise && !core_r.scs_s[1] && core_r.panel_show_enable_s[1] && !core_r.pend)
      |=> core_r.pol != $past(core_r.pol))
      else $error("inversion edge ignored");
   chk_erase_white: assert property (@(posedge CLK) disable iff (RESET)
      $rose(core_r.clr_busy) |-> (mem.we && mem.wdata == PIX_WHITE) [*8])
      else $error("erase sweep not writing white");
   chk_line_write: assert property (@(posedge CLK) disable iff (RESET)
      (wr_evt && !core_r.clr_busy) |-> mem.we && mem.waddr == hold_r.addr
      ##1 core_r.last_line == $past(hold_r.addr))
      else $error("line write misdirected");

   cov_update_line: cover property (@(posedge CLK) disable iff (RESET)
      wr_evt && !core_r.clr_busy);
   cov_all_clear: cover property (@(posedge CLK) disable iff (RESET)
      $fell(core_r.clr_busy));
   cov_pending_flip: cover property (@(posedge CLK) disable iff (RESET)
      scs_fall && core_r.pend && core_r.panel_show_enable_s[1]);
endmodule : memory_lcd_serial_update

// [testbench/lcd_host.sv]
// Host model driving the panel serial update link
`timescale 1ns/1ps
module lcd_host
   import lcd_pkg::*;
(
   output logic SCS,
   output logic SCLK,
   output logic SI
);
   // Link idle: clock stands still outside frames
   // Short select pulse at start gives the receiver a real reset edge
   initial
   begin
      SCS  = 1'b1;
      SCLK = 1'b0;
      SI   = 1'b0;
      #1 SCS = 1'b0;
   end

   // One bit: data set while clock low, taken on the rise
   task automatic put_bit(input logic b);
      SI = b;
      #32 SCLK = 1'b1;
      #32 SCLK = 1'b0;
   endtask : put_bit

   // Mode field, n whole lines, then closing dummies
   task automatic frame(input logic [7:0] mode, input int n,
                        input logic [ADDR_W-1:0] a [2], input logic [PIX_W-1:0] p [2]);
      SCS = 1'b1;
      #6000;
      for (int i = 0; i < MODE_BITS; i++) put_bit(mode[i]);
      for (int l = 0; l < n; l++)
      begin
         for (int i = 0; i < ADDR_W; i++) put_bit(a[l][i]);
         for (int i = 0; i < PIX_W; i++) put_bit(p[l][i]);
         for (int i = 0; i < LINE_DUMMY; i++) put_bit(1'b0);
      end
      for (int i = 0; i < 16; i++) put_bit(1'b0);
      #2000 SCS = 1'b0;
      SI = ~SI; // Released line shows no stale level
   endtask : frame
endmodule : lcd_host

// [testbench/tb.sv]
// Self-checking bench for the panel serial update receiver
`timescale 1ns/1ps
module tb
   import lcd_pkg::*;
();
   logic              clk, reset, scs, sclk, si, show_en, inv_in, polarity, clear_busy, rd_v;
   logic [ADDR_W-1:0] scan_line, last_line;
   logic [PIX_W-1:0]  scan_pixels, row1;
   logic [ADDR_W-1:0] a [2];
   logic [PIX_W-1:0]  p [2];
   logic [PIX_W-1:0]  exp_q [$];
   logic [7:0]        busy_q [$];
   logic [7:0]        modes [3] = '{8'h00, 8'h02, 8'h05};
   int                err_count, total_checks, cycles, busy_n;

   memory_lcd_serial_update u_memory_lcd_serial_update (.CLK(clk), .RESET(reset),
      .SCLK(sclk), .SCS(scs), .SI(si), .PANEL_SHOW_ENABLE(show_en),
      .COMMON_INVERT_IN(inv_in), .SCAN_LINE(scan_line), .SCAN_PIXELS(scan_pixels),
      .COMMON_POLARITY(polarity), .CLEAR_BUSY(clear_busy), .LAST_LINE(last_line));
   lcd_host u_lcd_host (.SCS(scs), .SCLK(sclk), .SI(si));

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task automatic cmp_row(input logic [PIX_W-1:0] got, input logic [PIX_W-1:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED at %0t: row data mismatch", $time);
      end
   endtask : cmp_row

   task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED at %0t: status %h, expected %h", $time, got, exp);
      end
   endtask : cmp_val

   // Read one row; the monitor compares it a half cycle later
   task automatic read_row(input logic [ADDR_W-1:0] r, input logic [PIX_W-1:0] e);
      scan_line = r;
      tick(1);
      exp_q.push_back(e);
      rd_v = 1'b1;
      tick(1);
      rd_v = 1'b0;
   endtask : read_row

   task automatic conclude();
      if (busy_q.size() != 0) err_count++;
      if (err_count == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : conclude

   // -----------------------------------------------------------------
   // Clock, hang guard and result monitors
   // -----------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Hang guard; also measures each erase run against the noted length
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 30000)
      begin
         err_count++;
         conclude();
      end
      if (clear_busy === 1'b1)
         busy_n <= busy_n + 1;
      else if (busy_n != 0)
      begin
         cmp_val(8'(busy_n), busy_q.pop_front());
         busy_n <= 0;
      end
   end

   // Settled read data sampled mid-cycle
   always @(negedge clk)
      if (rd_v) cmp_row(scan_pixels, exp_q.pop_front());

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial
   begin
      reset = 1'b0;
      show_en = 1'b0;
      inv_in = 1'b0;
      scan_line = '0;
      rd_v = 1'b0;
      err_count = 0;
      total_checks = 0;
      cycles = 0;
      busy_n = 0;
      void'($urandom(32'haa56));
      // Reset rises after time zero so the link-side latch sees an edge
      #2 reset = 1'b1;
      tick(8);
      reset = 1'b0;
      tick(3);
      cmp_val(8'(polarity), 8'h00);
      cmp_val(8'(last_line), 8'h00);
      busy_q.push_back(8'(LINES));
      u_lcd_host.frame(8'h04, 0, a, p);
      tick(100);
      read_row(6'h00, PIX_WHITE);
      read_row(ADDR_LAST, PIX_WHITE);
      show_en = 1'b1;
      tick(1500);
      inv_in = 1'b1;
      tick(8);
      cmp_val(8'(polarity), 8'h01);
      tick(100);
      inv_in = 1'b0;
      show_en = 1'b0;
      tick(8);
      inv_in = 1'b1;
      tick(100);
      cmp_val(8'(polarity), 8'h01);
      inv_in = 1'b0;
      show_en = 1'b1;
      tick(1500);
      a[0] = 6'h01;
      a[1] = 6'h20;
      for (int l = 0; l < 2; l++)
         p[l] = PIX_W'({$urandom(), $urandom(), $urandom(), $urandom(), $urandom(), $urandom()});
      // Spare flag high on purpose; row 1 must stay old mid-line
      fork
         u_lcd_host.frame(8'h03, 2, a, p);
         begin
            tick(500);
            read_row(6'h01, PIX_WHITE);
            // Inversion inside a frame waits for chip select to drop
            inv_in = 1'b1;
            tick(8);
            cmp_val(8'(polarity), 8'h01);
         end
      join
      tick(20);
      cmp_val(8'(polarity), 8'h00);
      inv_in = 1'b0;
      cmp_val(8'(last_line), 8'h20);
      read_row(6'h01, p[0]);
      read_row(6'h20, p[1]);
      row1 = p[0];
      p[0] = ~row1;
      // Display, spare-only and conflicting flags keep memory
      for (int m = 0; m < 3; m++)
      begin
         u_lcd_host.frame(modes[m], 1, a, p);
         tick(20);
         read_row(6'h01, row1);
         cmp_val(8'(last_line), 8'h20);
      end
      busy_q.push_back(8'(LINES));
      u_lcd_host.frame(8'h04, 0, a, p);
      tick(100);
      read_row(6'h20, PIX_WHITE);
      show_en = 1'b0;
      tick(1500);
      conclude();
   end
endmodule : tb
